// file: dv/dpg_load_model.sv
`timescale 1ns/1ps
`default_nettype none
module dpg_load_model (
    // output stage
    input wire logic [7:0] pwm_drive,
    input wire logic [7:0] pwm_ctrl,
    // lamp state
    output logic [7:0] load_on
);
    assign load_on = pwm_drive & pwm_ctrl;
endmodule : dpg_load_model
`default_nettype wire

// file: dv/dpg_pwm_config_props.sv
`timescale 1ns/1ps
`default_nettype none
module dpg_pwm_config_props (
    // clock, reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [dpg_pkg::FRAME_W-1:0] reg_frame,
    input wire logic [dpg_pkg::DATA_W-1:0] reg_rdata,
    input wire logic reg_rvalid,
    // output stage
    input wire logic [7:0] pwm_drive,
    input wire logic [7:0] pwm_ctrl
);
    import dpg_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_en_wr;
        reg_wr && reg_frame[13:8] == ADDR_OUT_EN;
    endsequence
    chk_rvalid_after_rd: assert property (reg_rd |=> reg_rvalid)
        else $error("read valid missing");
    chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read valid unasked");
    chk_drive_gated: assert property ((pwm_drive & ~pwm_ctrl) == 8'h00)
        else $error("drive without enable");
    chk_out_en_write: assert property (s_en_wr |-> ##2 pwm_ctrl == $past(reg_frame[7:0], 2))
        else $error("enable write lost");
    chk_rdata_held: assert property (!reg_rvalid |-> $stable(reg_rdata))
        else $error("read data moved");
    chk_ctrl_cause: assert property ($changed(pwm_ctrl) |-> $past(reg_wr, 2))
        else $error("enable moved unasked");
    chk_unmapped_zero: assert property (reg_rd && reg_frame[13:8] == 6'h3F |=> reg_rdata == 10'h000)
        else $error("unmapped read not zero");
    chk_en_readback: assert property (reg_rvalid && $past(reg_frame[13:8]) == ADDR_OUT_EN
        |-> reg_rdata == {2'h0, pwm_ctrl})
        else $error("enable readback wrong");
endmodule : dpg_pwm_config_props
`default_nettype wire

// file: dv/test_dual_pwm_generator_config.sv
`timescale 1ns/1ps
`default_nettype none
module test_dual_pwm_generator_config;
    import dpg_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid;
    logic [13:0] reg_frame = 14'h0000;
    logic [9:0] reg_rdata;
    logic [7:0] pwm_drive, pwm_ctrl, load_on;
    int bad_count = 0;
    int comparisons = 0;
    always #2 sys_clk = ~sys_clk;
    dpg_pwm_config dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_frame(reg_frame), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .pwm_drive(pwm_drive), .pwm_ctrl(pwm_ctrl));
    dpg_load_model load (.pwm_drive(pwm_drive), .pwm_ctrl(pwm_ctrl), .load_on(load_on));
    task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [13:0] f);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_frame <= f;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input string n, input logic [13:0] f, input logic [9:0] e);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_frame <= f;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk("rvalid", 10'h001, {9'h000, reg_rvalid});
        chk(n, e, reg_rdata);
    endtask : rd
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : hold
    task automatic t_reset;
        rd("trim", {ADDR_TRIM, 8'h00}, 10'h080);
        rd("gen0", {CODE_GEN0, 10'h000}, 10'h000);
        rd("out_en", {ADDR_OUT_EN, 8'h00}, 10'h000);
        rd("unmapped", 14'h3F00, 10'h000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_force;
        wr({CODE_GEN0, 10'h300});
        wr({ADDR_TRIM, 8'h81});
        hold(4);
        chk("no enable", 10'h000, {2'h0, pwm_drive});
        wr({ADDR_OUT_EN, 8'h01});
        hold(4);
        chk("forced on", 10'h001, {2'h0, load_on});
        wr({ADDR_OUT_SEL, 8'h02});
        wr({ADDR_OUT_EN, 8'h03});
        hold(4);
        chk("gen1 off", 10'h001, {2'h0, load_on});
        chk("ctrl", 10'h003, {2'h0, pwm_ctrl});
        wr({CODE_GEN0, 10'h000});
        hold(4);
        chk("duty zero", 10'h000, {2'h0, load_on});
        $display("test force done");
    endtask : t_force
    task automatic t_range;
        // duty one: first step high, its length set by range and divider
        wr({CODE_GEN1, 10'h201});
        wr({ADDR_TRIM, 8'h82});
        hold(1000);
        chk("low range", 10'h002, {2'h0, load_on});
        wr({ADDR_TRIM, 8'h80});
        wr({ADDR_TRIM, 8'h8A});
        hold(100);
        chk("high first", 10'h002, {2'h0, load_on});
        hold(900);
        chk("high range", 10'h000, {2'h0, load_on});
        $display("test range done");
    endtask : t_range
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_force();
        t_range();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        tally_and_finish();
    end
endmodule : test_dual_pwm_generator_config
bind dpg_pwm_config dpg_pwm_config_props props (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_frame(reg_frame), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .pwm_drive(pwm_drive), .pwm_ctrl(pwm_ctrl));
`default_nettype wire

// file: hw/dpg_pkg.sv
package dpg_pkg;
    // register frame: six address bits above eight data bits
    localparam int FRAME_W = 14;
    localparam int DATA_W = 10;
    localparam logic [5:0] ADDR_TRIM = 6'h0E;
    localparam logic [5:0] ADDR_OUT_EN = 6'h24;
    localparam logic [5:0] ADDR_OUT_SEL = 6'h27;
    // generator registers use a four-bit code; divider rides in the low address bits
    localparam logic [3:0] CODE_GEN0 = 4'h4;
    localparam logic [3:0] CODE_GEN1 = 4'h5;

    localparam logic [7:0] TRIM_RST = 8'h80;
    localparam logic [9:0] GEN_CFG_RST = 10'h000;
    localparam logic [7:0] OUT_EN_RST = 8'h00;
    localparam logic [7:0] OUT_SEL_RST = 8'h00;

    localparam int TRIM_MSB = 7;
    localparam int TRIM_LSB = 4;
    localparam int RANGE1_BIT = 3;
    localparam int RANGE0_BIT = 2;
    localparam int EN1_BIT = 1;
    localparam int EN0_BIT = 0;
    localparam int DIV_MSB = 9;
    localparam int DIV_LSB = 8;
    localparam int DUTY_MSB = 7;

    localparam logic [1:0] DIV_1024 = 2'h0;
    localparam logic [1:0] DIV_512 = 2'h1;
    localparam logic [1:0] DIV_256 = 2'h2;
    localparam logic [1:0] DIV_FORCE_ON = 2'h3;

    // timing: fine tick runs at FINE_MULT times the internal base clock
    localparam longint CLK_HZ = 250_000_000;
    localparam longint FINT_HZ = 102_400;
    localparam longint FINE_MULT = 20;
    localparam int FINE_PERIOD_CYC = int'(CLK_HZ / (FINT_HZ * FINE_MULT));
    localparam int DUTY_STEPS = 256;
    // fine ticks per duty step: divider / 256 * FINE_MULT
    localparam logic [6:0] STEP_LO_1024 = 7'h50;
    localparam logic [6:0] STEP_LO_512 = 7'h28;
    localparam logic [6:0] STEP_LO_256 = 7'h14;
    localparam logic [6:0] STEP_HI_128 = 7'h0A;
    localparam logic [6:0] STEP_HI_64 = 7'h05;
    localparam logic [6:0] STEP_HI_51 = 7'h04;

    // trim offsets in tenths of a percent, index = trim code
    localparam int TRIM_PERMIL [16] = '{0, -372, -319, -269, -210, -155, -109, -58,
                                        0, 43, 89, 140, 195, 256, 324, 400};
endpackage : dpg_pkg

// file: hw/dpg_pwm_config.sv
`timescale 1ns/1ps
`default_nettype none
module dpg_pwm_config (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [dpg_pkg::FRAME_W-1:0] reg_frame,
    output logic [dpg_pkg::DATA_W-1:0] reg_rdata,
    output logic reg_rvalid,
    // output stage
    output logic [7:0] pwm_drive,
    output logic [7:0] pwm_ctrl
);
    import dpg_pkg::*;

    localparam int NGEN = 2;

    // refuse a clock that the eight-bit prescaler cannot serve
    if (FINE_PERIOD_CYC < 2 || FINE_PERIOD_CYC > 255) begin : g_bad_period
        $error("fine tick period out of range");
    end

    // fine tick periods per trim code, worked out at elaboration
    function automatic logic [7:0] trim_period(input int code);
        int p;
        p = (FINE_PERIOD_CYC * 1000) / (1000 + TRIM_PERMIL[code]);
        return 8'(p);
    endfunction : trim_period

    function automatic logic [6:0] step_len(input logic range_hi, input logic [1:0] div);
        logic [6:0] r;
        r = range_hi ? STEP_HI_128 : STEP_LO_1024;
        unique case (div)
            DIV_512: r = range_hi ? STEP_HI_64 : STEP_LO_512;
            DIV_256: r = range_hi ? STEP_HI_51 : STEP_LO_256;
            default: r = range_hi ? STEP_HI_128 : STEP_LO_1024;
        endcase
        return r;
    endfunction : step_len

    logic [7:0] trim_ctrl;
    logic [9:0] gen_cfg [NGEN];
    logic [7:0] out_en;
    logic [7:0] out_sel;

    wire logic [5:0] frame_addr = reg_frame[13:8];
    wire logic [3:0] frame_code = reg_frame[13:10];
    wire logic [7:0] frame_data = reg_frame[7:0];
    wire logic hit_trim = frame_addr == ADDR_TRIM;
    wire logic hit_out_en = frame_addr == ADDR_OUT_EN;
    wire logic hit_out_sel = frame_addr == ADDR_OUT_SEL;
    wire logic hit_gen0 = frame_code == CODE_GEN0;
    wire logic hit_gen1 = frame_code == CODE_GEN1;

    // register writes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            trim_ctrl <= TRIM_RST;
            gen_cfg[0] <= GEN_CFG_RST;
            gen_cfg[1] <= GEN_CFG_RST;
            out_en <= OUT_EN_RST;
            out_sel <= OUT_SEL_RST;
        end else if (reg_wr) begin
            if (hit_trim) trim_ctrl <= frame_data;
            if (hit_gen0) gen_cfg[0] <= reg_frame[9:0];
            if (hit_gen1) gen_cfg[1] <= reg_frame[9:0];
            if (hit_out_en) out_en <= frame_data;
            if (hit_out_sel) out_sel <= frame_data;
        end
    end

    // read mux; unmapped addresses answer zero
    logic [9:0] next_rdata;
    always_comb begin
        next_rdata = '0;
        if (hit_trim) next_rdata = {2'h0, trim_ctrl};
        else if (hit_gen0) next_rdata = gen_cfg[0];
        else if (hit_gen1) next_rdata = gen_cfg[1];
        else if (hit_out_en) next_rdata = {2'h0, out_en};
        else if (hit_out_sel) next_rdata = {2'h0, out_sel};
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) reg_rdata <= next_rdata;
        end
    end

    // trimmed base clock; reserved code 0000b runs nominal
    logic [7:0] trim_per [16];
    for (genvar t = 0; t < 16; t++) begin : g_trim
        assign trim_per[t] = trim_period(t);
    end
    wire logic [7:0] fine_period = trim_per[trim_ctrl[TRIM_MSB:TRIM_LSB]];
    logic [7:0] pre_cnt;
    wire logic fine_tick = pre_cnt >= fine_period - 8'h01;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) pre_cnt <= '0;
        else pre_cnt <= fine_tick ? 8'h00 : pre_cnt + 8'h01;
    end

    // the two generators
    wire logic [NGEN-1:0] gen_en = {trim_ctrl[EN1_BIT], trim_ctrl[EN0_BIT]};
    wire logic [NGEN-1:0] gen_range = {trim_ctrl[RANGE1_BIT], trim_ctrl[RANGE0_BIT]};
    logic [NGEN-1:0] gen_out;

    for (genvar g = 0; g < NGEN; g++) begin : g_gen
        logic [6:0] tick_cnt;
        logic [7:0] phase;
        wire logic [1:0] div = gen_cfg[g][DIV_MSB:DIV_LSB];
        wire logic [7:0] duty = gen_cfg[g][DUTY_MSB:0];
        wire logic [6:0] len = step_len(gen_range[g], div);
        // >= so a shortened step after a divider change cannot overrun
        wire logic step_done = tick_cnt >= len - 7'h01;

        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                tick_cnt <= '0;
                phase <= '0;
            end else if (!gen_en[g]) begin
                tick_cnt <= '0;
                phase <= '0;
            end else if (fine_tick) begin
                tick_cnt <= step_done ? 7'h00 : tick_cnt + 7'h01;
                if (step_done) phase <= phase + 8'h01;
            end
        end

        // phase wraps at 256 steps, so all-ones duty stays low one step
        assign gen_out[g] = gen_en[g] & ((div == DIV_FORCE_ON) | (phase < duty));
    end

    // output mapping; select alone never hands an output to PWM
    wire logic [7:0] next_drive = out_en & ((out_sel & {8{gen_out[1]}})
                                           | (~out_sel & {8{gen_out[0]}}));

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwm_drive <= '0;
            pwm_ctrl <= '0;
        end else begin
            pwm_drive <= next_drive;
            pwm_ctrl <= out_en;
        end
    end
endmodule : dpg_pwm_config
`default_nettype wire
